// ---- core/ufc_core.sv ----
// enhanced flow control, special character and reset-state registers
`timescale 1ns/100ps
`include "ufc_params.svh"
// Function
// - with detect on, outside rx field 01, received chars matching stop two stored, status bit4 set
// - compare bit 0 against received char lsb
// - rx field 10: flow control and detect both work normally
// - rx field 01: stop-two match dropped, stop and special irq (ien5)
// - auto rts: irq at trigger, rts pin high at upper level
// - auto rts: rts pin low when fill below lower level and host rts bit set
// - auto rts off: rts pin follows host modem control bit
// - auto cts: transmit stops while cts high, resumes when low
// - detect, auto rts, auto cts enables reset to zero
// - four rw 8-bit flow characters, reset zero
// - stop char two also station address in 9-bit multidrop
// - divisor bytes reset only at power-up, not by reset pin
// - modem status reads low nibble zero, high nibble modem inputs
// - write-only upper modem status bits cleared after reset
// - enhanced enable gates writes to enhanced bits, clearing latches them
module ufc_core import ufc_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire ufc_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire ufc_char_t rx_char_i,
  input wire logic rx_addr_bit_i,
  input wire logic [4:0] rx_fill_i,
  input wire logic [4:0] rx_trig_i,
  input wire logic [4:0] rx_hyst_i,
  input wire logic cts_n_i,
  input wire logic [3:0] modem_n_i,
  input wire logic tx_serial_i,
  output logic fifo_push_o,
  output logic [7:0] fifo_data_o,
  output logic tx_allow_o,
  output logic addr_match_o,
  output logic tx_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic irq_o,
  output logic irq_oe_o
);
  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  typedef struct packed {
    logic [7:0] efc;
    logic [7:0] sta1;
    logic [7:0] sta2;
    logic [7:0] sto1;
    logic [7:0] sto2;
    logic [7:0] ien;
    logic [7:0] ist;
    logic [7:0] fcr;
    logic [7:0] mcr;
    logic [7:0] line_status;
    logic [3:0] msr_wo;
    logic [7:0] scratchpad;
    logic [7:0] fdv;
    logic [7:0] lcr;
    logic rts_hold;
    logic stop_irq;
    logic trig_irq;
    logic push;
    logic [7:0] pdata;
    logic amatch;
    logic [7:0] rdata;
    logic tx_en;
  } ufc_state_t;

  ufc_state_t st_ff;
  ufc_state_t nxt_st;
  logic cts_s;
  logic [3:0] modem_s;
  logic [7:0] dll_q;
  logic [7:0] dlm_q;
  logic wr_hit;
  logic enh_ok;
  logic scd_hit;

  // whole bus as argument so the strobe is part of the sensitivity
  function automatic logic sel(input ufc_bus_t b, input logic [4:0] r);
    sel = b.cs && b.wr && (b.addr == r);
  endfunction

  ufc_sync #(.W(5)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({cts_n_i, modem_n_i}),
    .init_i(5'h1f),
    .q_o({cts_s, modem_s})
  );

  // divisor bytes survive the reset pin
  ufc_dlatch u_dll (
    .core_clk_i(core_clk_i),
    .por_i(por_i),
    .we_i(sel(bus_i, `UFC_A_DLL)),
    .wdata_i(bus_i.wdata),
    .por_val_i(`UFC_POR_DLL),
    .q_o(dll_q)
  );
  ufc_dlatch u_dlm (
    .core_clk_i(core_clk_i),
    .por_i(por_i),
    .we_i(sel(bus_i, `UFC_A_DLM)),
    .wdata_i(bus_i.wdata),
    .por_val_i(`UFC_POR_DLM),
    .q_o(dlm_q)
  );

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    wr_hit = bus_i.cs && bus_i.wr;
    enh_ok = st_ff.efc[`UFC_EFC_ENH];
    nxt_st.push = 1'b0;
    nxt_st.pdata = st_ff.pdata;
    nxt_st.amatch = 1'b0;
    // register writes; enhanced fields only while enable set
    if (wr_hit) begin
      unique case (bus_i.addr)
        `UFC_A_EFC: nxt_st.efc = bus_i.wdata;
        `UFC_A_STA1: nxt_st.sta1 = bus_i.wdata;
        `UFC_A_STA2: nxt_st.sta2 = bus_i.wdata;
        `UFC_A_STO1: nxt_st.sto1 = bus_i.wdata;
        `UFC_A_STO2: nxt_st.sto2 = bus_i.wdata;
        `UFC_A_IEN: begin
          nxt_st.ien[3:0] = bus_i.wdata[3:0];
          if (enh_ok) nxt_st.ien[7:4] = bus_i.wdata[7:4];
        end
        `UFC_A_FCR: begin
          nxt_st.fcr[2:0] = bus_i.wdata[2:0];
          nxt_st.fcr[7:6] = bus_i.wdata[7:6];
          if (enh_ok) nxt_st.fcr[5:3] = bus_i.wdata[5:3];
        end
        `UFC_A_MCR: begin
          nxt_st.mcr[4:0] = bus_i.wdata[4:0];
          if (enh_ok) nxt_st.mcr[7:5] = bus_i.wdata[7:5];
        end
        `UFC_A_IST: begin
          // software clears status bits 5:4 only when enhanced
          if (enh_ok) nxt_st.ist[5:4] = st_ff.ist[5:4] & bus_i.wdata[5:4];
        end
        `UFC_A_MSR: nxt_st.msr_wo = bus_i.wdata[7:4];
        `UFC_A_SPR: nxt_st.scratchpad = bus_i.wdata;
        `UFC_A_FDV: if (enh_ok) nxt_st.fdv = bus_i.wdata;
        `UFC_A_LCR: nxt_st.lcr = bus_i.wdata;
        default: ;
      endcase
    end
    // status read clears the stop flag; a same-cycle set below wins
    if (bus_i.cs && bus_i.rd && bus_i.addr == `UFC_A_IST)
      nxt_st.stop_irq = 1'b0;
    // special character compare, bit 0 to lsb
    scd_hit = st_ff.efc[`UFC_EFC_SCD] && rx_char_i.valid &&
              (rx_char_i.data[7:0] == st_ff.sto2[7:0]);
    if (rx_char_i.valid) begin
      nxt_st.push = 1'b1;
      nxt_st.pdata = rx_char_i.data;
      if (st_ff.efc[1:0] == `UFC_RXF_FLOW_START_CHAR_TWO &&
          rx_char_i.data == st_ff.sto2) begin
        nxt_st.push = 1'b0;
        nxt_st.stop_irq = 1'b1;
        if (st_ff.ien[`UFC_IEN_SPC]) nxt_st.ist[`UFC_IST_SPC] = 1'b1;
      end else if (scd_hit) begin
        nxt_st.ist[`UFC_IST_SPC] = 1'b1;
      end
      if (st_ff.efc[1:0] == `UFC_RXF_FLOW_START_CHAR_ONE && rx_char_i.data == st_ff.sto1)
        nxt_st.stop_irq = 1'b1;
    end
    // address detect in 9-bit mode: address char vs stop two
    if (rx_char_i.valid && rx_addr_bit_i)
      nxt_st.amatch = (rx_char_i.data == st_ff.sto2);
    // auto rts with hysteresis band
    if (st_ff.efc[`UFC_EFC_ARTS]) begin
      nxt_st.trig_irq = (rx_fill_i >= rx_trig_i);
      // six bits: band edges must not wrap for large trigger or hysteresis
      if ({1'b0, rx_fill_i} >= {1'b0, rx_trig_i} + {1'b0, rx_hyst_i})
        nxt_st.rts_hold = 1'b1;
      else if ({1'b0, rx_fill_i} + {1'b0, rx_hyst_i} < {1'b0, rx_trig_i})
        nxt_st.rts_hold = 1'b0;
    end else begin
      nxt_st.trig_irq = 1'b0;
      nxt_st.rts_hold = 1'b0;
    end
    nxt_st.ist[0] = !(st_ff.stop_irq || st_ff.trig_irq ||
                      st_ff.ist[`UFC_IST_SPC]);
    // auto cts gates transmit
    nxt_st.tx_en = !(st_ff.efc[`UFC_EFC_ACTS] && cts_s);
    // read mux
    unique case (bus_i.addr)
      `UFC_A_EFC: nxt_st.rdata = st_ff.efc;
      `UFC_A_STA1: nxt_st.rdata = st_ff.sta1;
      `UFC_A_STA2: nxt_st.rdata = st_ff.sta2;
      `UFC_A_STO1: nxt_st.rdata = st_ff.sto1;
      `UFC_A_STO2: nxt_st.rdata = st_ff.sto2;
      `UFC_A_IEN: nxt_st.rdata = st_ff.ien;
      `UFC_A_IST: nxt_st.rdata = st_ff.ist;
      `UFC_A_FCR: nxt_st.rdata = st_ff.fcr;
      `UFC_A_MCR: nxt_st.rdata = st_ff.mcr;
      `UFC_A_LSR: nxt_st.rdata = st_ff.line_status;
      `UFC_A_MSR: nxt_st.rdata = {~modem_s, 4'h0};
      `UFC_A_SPR: nxt_st.rdata = st_ff.scratchpad;
      `UFC_A_DLL: nxt_st.rdata = dll_q;
      `UFC_A_DLM: nxt_st.rdata = dlm_q;
      `UFC_A_FDV: nxt_st.rdata = st_ff.fdv;
      `UFC_A_LCR: nxt_st.rdata = st_ff.lcr;
      default: nxt_st.rdata = 8'h00;
    endcase
  end

  // -----------------------------------------------------------
  // registers
  // -----------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.ist <= `UFC_RST_IST;
      st_ff.line_status <= `UFC_RST_LSR;
      st_ff.scratchpad <= `UFC_RST_SPR;
      st_ff.tx_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  assign rdata_o = st_ff.rdata;
  assign fifo_push_o = st_ff.push;
  assign fifo_data_o = st_ff.pdata;
  assign tx_allow_o = st_ff.tx_en;
  assign addr_match_o = st_ff.amatch;
  // mcr bit set means pin low; auto rts only lifts an asserted pin
  assign rts_n_o = rst_i ? 1'b1 :
    !(st_ff.mcr[`UFC_MCR_RTS] && !st_ff.rts_hold);
  assign dtr_n_o = rst_i ? 1'b1 : !st_ff.mcr[`UFC_MCR_DTR];
  assign tx_o = rst_i ? 1'b1 : tx_serial_i;
  assign irq_o = !st_ff.ist[0];
  assign irq_oe_o = !rst_i && st_ff.mcr[3];
endmodule // ufc_core

// ---- inc/ufc_params.svh ----
// constants: register offsets, reset values and field positions
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// -------------------------------------------------------------
// register offsets (own map, 5-bit address)
// -------------------------------------------------------------
`define UFC_A_EFC 5'h00
`define UFC_A_STA1 5'h01
`define UFC_A_STA2 5'h02
`define UFC_A_STO1 5'h03
`define UFC_A_STO2 5'h04
`define UFC_A_IEN 5'h05
`define UFC_A_IST 5'h06
`define UFC_A_FCR 5'h07
`define UFC_A_MCR 5'h08
`define UFC_A_LSR 5'h09
`define UFC_A_MSR 5'h0a
`define UFC_A_SPR 5'h0b
`define UFC_A_DLL 5'h0c
`define UFC_A_DLM 5'h0d
`define UFC_A_FDV 5'h0e
`define UFC_A_LCR 5'h0f
// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define UFC_RST_ZERO 8'h00
`define UFC_RST_IST 8'h01
`define UFC_RST_LSR 8'h60
`define UFC_RST_SPR 8'hff
`define UFC_POR_DLL 8'h01
`define UFC_POR_DLM 8'h00
// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define UFC_EFC_ENH 4
`define UFC_EFC_SCD 5
`define UFC_EFC_ARTS 6
`define UFC_EFC_ACTS 7
`define UFC_IEN_SPC 5
`define UFC_IST_SPC 4
`define UFC_MCR_RTS 1
`define UFC_MCR_DTR 0
`define UFC_RXF_FLOW_START_CHAR_ONE 2'b10
`define UFC_RXF_FLOW_START_CHAR_TWO 2'b01
`endif

// ---- inc/ufc_pkg.sv ----
// types shared by the flow-control block
package ufc_pkg;
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } ufc_bus_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufc_char_t;
endpackage

// ---- core/ufc_sync.sv ----
// two-flop synchroniser vector
`timescale 1ns/100ps
module ufc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] init_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  // constant reset: pins idle high, init_i masked to zero and never loaded
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff ^ (init_i & '0);
endmodule // ufc_sync

// ---- core/ufc_dlatch.sv ----
// divisor store, set at power-up only, immune to the reset pin
`timescale 1ns/100ps
module ufc_dlatch (
  input wire logic core_clk_i,
  input wire logic por_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] por_val_i,
  output logic [7:0] q_o
);
  logic [7:0] val_ff;
  logic [7:0] nxt_val;
  always_comb begin
    nxt_val = val_ff;
    if (por_i) begin
      nxt_val = por_val_i;
    end else if (we_i) begin
      nxt_val = wdata_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    val_ff <= nxt_val;
  end
  assign q_o = val_ff;
endmodule // ufc_dlatch

// ---- dv/ufc_properties.sv ----
// port checker of the flow-control block
`timescale 1ns/100ps
`include "ufc_params.svh"
module ufc_properties import ufc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ufc_bus_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire ufc_char_t rx_char_i,
  input wire logic [4:0] rx_fill_i,
  input wire logic [4:0] rx_trig_i,
  input wire logic [4:0] rx_hyst_i,
  input wire logic cts_n_i,
  input wire logic fifo_push_o,
  input wire logic [7:0] fifo_data_o,
  input wire logic tx_allow_o,
  input wire logic tx_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic irq_oe_o
);
  // --
  // checks
  // --
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // pins may lag a register write by one or two edges
  wire wr_any = bus_i.cs && bus_i.wr;
  wire sta1_wr = wr_any && bus_i.addr == `UFC_A_STA1;
  wire [5:0] hi = {1'b0, rx_trig_i} + {1'b0, rx_hyst_i};
  wire up = {1'b0, rx_fill_i} >= hi;
  wire dn = {1'b0, rx_fill_i} + {1'b0, rx_hyst_i} < {1'b0, rx_trig_i};
  // shadow of auto rts enable and host rts bit, rebuilt from bus writes
  logic arts_ff;
  logic rtsb_ff;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arts_ff <= 1'b0;
      rtsb_ff <= 1'b0;
    end else if (wr_any && bus_i.addr == `UFC_A_EFC) begin
      arts_ff <= bus_i.wdata[`UFC_EFC_ARTS];
    end else if (wr_any && bus_i.addr == `UFC_A_MCR) begin
      rtsb_ff <= bus_i.wdata[`UFC_MCR_RTS];
    end
  end
  a_reset_pins: assert property (disable iff (1'b0)
    rst_i |-> tx_o && rts_n_o && dtr_n_o && !irq_oe_o)
    else $error("reset pins");
  a_rts_manual: assert property (
    !arts_ff && !$past(arts_ff) |-> rts_n_o == !rtsb_ff)
    else $error("rts manual");
  a_push_data: assert property (
    fifo_push_o |-> $past(rx_char_i.valid) &&
    fifo_data_o == $past(rx_char_i.data)) else $error("push data");
  a_unmapped_read: assert property (
    bus_i.cs && bus_i.rd && bus_i.addr > 5'h0f |=> rdata_o == 8'h00)
    else $error("unmapped read");
  a_write_read: assert property (
    bus_i.cs && bus_i.rd && bus_i.addr == `UFC_A_STA1 && $past(sta1_wr, 2)
    |=> rdata_o == $past(bus_i.wdata, 3)) else $error("write read");
  a_rts_rise: assert property (
    $rose(rts_n_o) |-> $past(wr_any) || $past(wr_any, 2) || $past(up) ||
    $past(up, 2)) else $error("rts rise");
  a_rts_fall: assert property (
    $fell(rts_n_o) |-> $past(wr_any) || $past(wr_any, 2) || $past(dn) ||
    $past(dn, 2)) else $error("rts fall");
  a_cts_stop: assert property (
    !tx_allow_o |-> $past(cts_n_i, 2) || $past(cts_n_i, 3))
    else $error("cts stop");
  a_gpo_source: assert property (
    $changed(dtr_n_o) || $changed(irq_oe_o) |-> $past(wr_any) ||
    $past(wr_any, 2)) else $error("gpo source");
  cover property (fifo_push_o);
  cover property ($rose(rts_n_o));
  cover property ($fell(tx_allow_o));
endmodule // ufc_properties
bind ufc_core ufc_properties u_props (.core_clk_i, .rst_i, .bus_i, .rdata_o,
  .rx_char_i, .rx_fill_i, .rx_trig_i, .rx_hyst_i, .cts_n_i, .fifo_push_o,
  .fifo_data_o, .tx_allow_o, .tx_o, .rts_n_o, .dtr_n_o, .irq_oe_o);

// ---- dv/ufc_remote.sv ----
// remote serial end: received chars and clear-to-send
`timescale 1ns/100ps
module ufc_remote import ufc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic send_i,
  input wire logic [7:0] char_i,
  input wire logic stop_i,
  output ufc_char_t rx_char_o,
  output logic cts_n_o
);
  // --
  // line model
  // --
  // idle data inverts each cycle so a stale byte never matches
  initial rx_char_o = '0;
  initial cts_n_o = 1'b0;
  always @(negedge core_clk_i) begin
    rx_char_o.valid <= send_i;
    rx_char_o.data <= send_i ? char_i : ~rx_char_o.data;
    cts_n_o <= stop_i;
  end
endmodule // ufc_remote

// ---- dv/ufc_core_bench.sv ----
// self-checking bench of the flow-control block
`timescale 1ns/100ps
`include "ufc_params.svh"
module ufc_core_bench import ufc_pkg::*; ();
  // --
  // stimulus and checks
  // --
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic send = 1'b0;
  logic stop = 1'b0;
  logic exp_rts;
  logic [7:0] ch = 8'h00;
  logic [7:0] d;
  logic [4:0] fill = 5'h00;
  logic [4:0] trig = 5'h08;
  logic [4:0] hyst = 5'h02;
  logic [3:0] modem_n = 4'h0;
  logic abit = 1'b0;
  logic txd = 1'b0;
  ufc_bus_t bus = '0;
  ufc_char_t rx_char;
  logic [7:0] rdata;
  logic cts_n, push, allow, tx, rts_n, dtr_n, irq, irq_oe, amatch;
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'hb946;
  logic [7:0] modes [3] = '{8'h30, 8'h32, 8'h31};
  logic [12:0] rv [16] = '{{`UFC_A_EFC, 8'h00}, {`UFC_A_STA1, 8'h00},
    {`UFC_A_STA2, 8'h00}, {`UFC_A_STO1, 8'h00}, {`UFC_A_STO2, 8'h00},
    {`UFC_A_IEN, 8'h00}, {`UFC_A_IST, 8'h01}, {`UFC_A_FCR, 8'h00},
    {`UFC_A_MCR, 8'h00}, {`UFC_A_LSR, 8'h60}, {`UFC_A_SPR, 8'hff},
    {`UFC_A_DLL, 8'h01}, {`UFC_A_DLM, 8'h00}, {`UFC_A_FDV, 8'h00},
    {`UFC_A_LCR, 8'h00}, {5'h1f, 8'h00}};
  initial forever #5 core_clk_i = ~core_clk_i;
  ufc_core dut (.core_clk_i, .rst_i, .por_i, .bus_i(bus), .rdata_o(rdata),
    .rx_char_i(rx_char), .rx_addr_bit_i(abit), .rx_fill_i(fill),
    .rx_trig_i(trig), .rx_hyst_i(hyst), .cts_n_i(cts_n),
    .modem_n_i(modem_n), .tx_serial_i(txd), .fifo_push_o(push),
    .fifo_data_o(), .tx_allow_o(allow), .addr_match_o(amatch), .tx_o(tx),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_o(irq), .irq_oe_o(irq_oe));
  ufc_remote peer (.core_clk_i, .send_i(send), .char_i(ch), .stop_i(stop),
    .rx_char_o(rx_char), .cts_n_o(cts_n));
  // band hold: between the levels the pin keeps its last state
  function automatic logic rts_next(input logic p, input logic [4:0] f);
    if (f >= trig + hyst) return 1'b1;
    if (f + hyst < trig) return 1'b0;
    return p;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge core_clk_i);
    bus = '{1'b1, 1'b1, 1'b0, a, v};
    @(negedge core_clk_i);
    bus = '0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    @(negedge core_clk_i);
    bus = '{1'b1, 1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk_i);
    bus = '0;
    chk(rdata & m, e);
  endtask
  task automatic send_char(input logic [7:0] c);
    @(negedge core_clk_i);
    send <= 1'b1;
    ch <= c;
    @(negedge core_clk_i);
    send <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    modem_n = 4'($random(seed));
    cyc(16);
    chk({tx, rts_n, dtr_n, irq_oe}, 8'h0e);
    rst_i = 1'b0;
    por_i = 1'b0;
    foreach (rv[i]) rd(rv[i][12:8], rv[i][7:0]);
    rd(`UFC_A_MSR, {~modem_n, 4'h0});
    chk(tx, txd);
    wr(`UFC_A_IEN, 8'h20);
    rd(`UFC_A_IEN, 8'h00);
    wr(`UFC_A_EFC, 8'h10);
    wr(`UFC_A_IEN, 8'hf0);
    wr(`UFC_A_EFC, 8'h00);
    wr(`UFC_A_IEN, 8'h00);
    rd(`UFC_A_IEN, 8'hf0);
    $display("test reset and gating done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(5'(`UFC_A_STA1 + i % 4), d);
      rd(5'(`UFC_A_STA1 + i % 4), d);
    end
    d = 8'($random(seed));
    wr(`UFC_A_DLL, d);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    rd(`UFC_A_DLL, d);
    $display("test registers done");
    wr(`UFC_A_MCR, 8'h0b);
    cyc(3);
    chk({rts_n, dtr_n, irq_oe}, 8'h01);
    wr(`UFC_A_MCR, 8'h00);
    cyc(3);
    chk({rts_n, dtr_n, irq_oe}, 8'h06);
    wr(`UFC_A_MCR, 8'h02);
    wr(`UFC_A_EFC, 8'h50);
    exp_rts = 1'b0;
    for (int i = 0; i < 12; i++) begin
      fill = (i < 3) ? 5'(i == 0 ? 10 : 7 - i) :
        5'($unsigned($random(seed)) % 17);
      cyc(4);
      exp_rts = rts_next(exp_rts, fill);
      chk(rts_n, exp_rts);
      chk(irq, fill >= trig);
    end
    fill = 5'h00;
    $display("test rts done");
    d = 8'($random(seed));
    wr(`UFC_A_STO2, d);
    wr(`UFC_A_EFC, 8'h10);
    wr(`UFC_A_IEN, 8'h20);
    foreach (modes[i]) begin
      wr(`UFC_A_IST, 8'h00);
      wr(`UFC_A_EFC, modes[i]);
      send_char(d);
      chk(push, !modes[i][0]);
      cyc(1);
      chk(irq, 1'b1);
      rd(`UFC_A_IST, 8'h10, 8'h10);
    end
    abit = 1'b1;
    send_char(d);
    chk(amatch, 1'b1);
    send_char(d ^ 8'h01);
    chk(push, 1'b1);
    chk(amatch, 1'b0);
    abit = 1'b0;
    $display("test special char done");
    wr(`UFC_A_EFC, 8'h90);
    stop <= 1'b1;
    cyc(6);
    chk(allow, 1'b0);
    stop <= 1'b0;
    cyc(6);
    chk(allow, 1'b1);
    $display("test cts done");
    complete_run();
  end
endmodule // ufc_core_bench
